/* rtl/twt_engine.sv */
// Purpose: Bit-level target side of a two-wire serial memory interface
// Assumes: scl, sda, address straps and power-good come from outside this clock
// Notes:   Received bytes pass through a buffer; a full buffer answers no-ack
//
// Overview of operation
// RL1: Ignore the bus until power-on reset releases, then go to standby.
// RL2: Master waits 100 us after stable supply before its first command.
// RL3: Sample data on clock rise; change driven data only after clock fall.
// RL4: Bytes go most significant bit first, eight bits plus an answer clock.
// RL5: No pauses or spare clocks inside the nine clocks of a byte.
// RL6: Data changes only while clock is low, outside start and stop.
// RL7: Data falling while clock high is a start; it wakes from standby.
// RL8: Data rising while clock high is a stop; back to standby unless writing.
// RL9: Watch for start always; stay silent on the bus until one arrives.
// RL10: Bus is idle only while clock and data are both high.
// RL11: A repeated start begins a fresh command.
// RL12: Sender frees data after eighth bit; receiver holds low through ninth clock.
// RL13: Receiver releases data at the end of the ninth clock.
// RL14: High answer while device sends is no-ack; device releases the line.
// RL15: Standby after power-up, after a non-writing stop, after write completes.
// RL16: No limit on bytes between start and stop.
// RL17: Master recovers with up to nine dummy clocks until data released high.
// RL18: Acknowledge the first byte only when it carries this device's address.
// RL19: Start or stop mid-byte abandons the byte and clears the bit count.
`timescale 1ns/1ps

// ==========================================================
// Receive buffer
module twt_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic             do_wr;
	logic             do_rd;
	logic [AW-1:0]    rd_next;
	logic [AW:0]      count_next;
	logic             valid_reg;
	logic [WIDTH-1:0] head_reg;

	// Full and empty come from the count, so both are exact
	assign in_ready   = (count_reg != (AW + 1)'(DEPTH));
	assign out_valid  = valid_reg;
	assign out_data   = head_reg;
	assign do_wr      = in_valid && in_ready;
	assign do_rd      = out_valid && out_ready;
	assign rd_next    = rd_ptr_reg + AW'(do_rd);
	assign count_next = count_reg + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);

	// Pointers wrap by width, so the depth must be a power of two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			valid_reg  <= 1'b0;
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			count_reg <= count_next;
			valid_reg <= (count_next != '0);
		end
	end

	// Storage needs no reset; only written entries are ever read
	// Head is registered so the output leaves a flop; a write into the
	// slot that becomes the head bypasses the memory
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr_reg] <= in_data;
		end
		if (do_wr && wr_ptr_reg == rd_next) begin
			head_reg <= in_data;
		end else begin
			head_reg <= mem[rd_next];
		end
	end
endmodule

// ==========================================================
// Engine top
module twt_engine
	import twt_pkg::*;
#(
	parameter int FIFO_WIDTH = TWT_FIFO_WIDTH,
	parameter int FIFO_DEPTH = TWT_FIFO_DEPTH
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  por_release,
	input  wire logic [2:0]            dev_addr,
	input  wire logic                  scl_i,
	input  wire logic                  sda_i,
	output logic                       sda_o,
	output logic                       sda_oe,
	input  wire logic                  write_busy,
	input  wire logic [7:0]            tx_data,
	output logic                       tx_take,
	output logic                       rx_valid,
	input  wire logic                  rx_ready,
	output logic      [FIFO_WIDTH-1:0] rx_data,
	output logic                       standby,
	output logic                       bus_idle,
	output logic                       start_seen,
	output logic                       stop_seen,
	output logic                       write_launch
);
	twt_regs_t st_reg;
	twt_regs_t st_next;
	logic      scl_rise;
	logic      scl_fall;
	logic      start_c;
	logic      stop_c;
	logic      fifo_ready;
	logic      addr_hit;

	// Edges come from the second sync stage against its delayed copy
	assign scl_rise = st_reg.scl_s2 && !st_reg.scl_d;
	assign scl_fall = !st_reg.scl_s2 && st_reg.scl_d;
	assign start_c  = st_reg.scl_s2 && st_reg.scl_d && st_reg.sda_d && !st_reg.sda_s2; // RL7
	assign stop_c   = st_reg.scl_s2 && st_reg.scl_d && !st_reg.sda_d && st_reg.sda_s2; // RL8
	// Busy writes refuse the address so the master can poll
	assign addr_hit = (st_reg.shreg[7:1] == {TWT_TYPE_ID, st_reg.addr_s2}) && !write_busy;

	// Next-state logic for the whole engine
	always_comb begin
		st_next          = st_reg;
		st_next.scl_s1   = scl_i;
		st_next.scl_s2   = st_reg.scl_s1;
		st_next.scl_d    = st_reg.scl_s2;
		st_next.sda_s1   = sda_i;
		st_next.sda_s2   = st_reg.sda_s1;
		st_next.sda_d    = st_reg.sda_s2;
		st_next.por_s1   = por_release;
		st_next.por_s2   = st_reg.por_s1;
		st_next.addr_s1  = dev_addr;
		st_next.addr_s2  = st_reg.addr_s1;
		st_next.sda_o    = 1'b0;
		st_next.bus_idle = st_reg.scl_s2 && st_reg.sda_s2; // RL10
		st_next.start_p  = 1'b0;
		st_next.stop_p   = 1'b0;
		st_next.launch_p = 1'b0;
		st_next.take_p   = 1'b0;
		st_next.push     = 1'b0;
		if (st_reg.state == TWT_ST_POR) begin
			// Bus traffic is ignored until power is good
			st_next.sda_oe = 1'b0; // RL1
			if (st_reg.por_s2) begin
				st_next.state = TWT_ST_STANDBY; // RL1 RL15
			end
		end else if (start_c) begin
			// Any start after power-on release, repeated or not, restarts the command
			st_next.state      = TWT_ST_ADDR; // RL7 RL11
			st_next.bitcnt     = 4'h0; // RL19
			st_next.bit_armed  = 1'b0; // RL19
			st_next.sda_oe     = 1'b0;
			st_next.wr_pending = 1'b0;
			st_next.start_p    = 1'b1;
		end else if (stop_c) begin
			st_next.state      = TWT_ST_STANDBY; // RL8 RL15
			st_next.bitcnt     = 4'h0; // RL19
			st_next.sda_oe     = 1'b0;
			st_next.stop_p     = 1'b1;
			st_next.launch_p   = st_reg.wr_pending; // RL8
			st_next.wr_pending = 1'b0;
		end else if (st_reg.state == TWT_ST_STANDBY || st_reg.state == TWT_ST_IGNORE) begin
			// Silent until a start; clocks here only let the master recover
			st_next.sda_oe = 1'b0; // RL9 RL17
		end else if (scl_rise) begin
			st_next.bit_armed = 1'b1;
			if (st_reg.bitcnt != TWT_ACK_SLOT) begin
				// Shift in on the rising edge, first bit lands on top; a send
				// shifts on the fall only, or it would skip bits
				if (st_reg.state != TWT_ST_TX) begin
					st_next.shreg = {st_reg.shreg[6:0], st_reg.sda_s2}; // RL3 RL4
				end
			end else if (st_reg.state == TWT_ST_TX && st_reg.sda_s2) begin
				// No-ack from the master ends the read
				st_next.state  = TWT_ST_IGNORE; // RL14
				st_next.sda_oe = 1'b0; // RL14
			end
		end else if (scl_fall && st_reg.bit_armed) begin // RL6
			// Drive changes only ever happen here, after the clock falls; the
			// fall that closes a start holds no bit and is not counted
			if (st_reg.bitcnt == TWT_LAST_DATA_BIT) begin
				st_next.bitcnt = TWT_ACK_SLOT;
				case (st_reg.state)
					TWT_ST_ADDR: begin
						st_next.sda_oe = addr_hit; // RL18 RL12
						if (!addr_hit) begin
							st_next.state = TWT_ST_IGNORE; // RL18
						end
					end
					TWT_ST_RX: begin
						// A full buffer answers no-ack so no byte is lost
						st_next.sda_oe = fifo_ready; // RL12
						st_next.push   = fifo_ready;
						st_next.wr_pending = st_reg.wr_pending || fifo_ready;
					end
					default: begin
						st_next.sda_oe = 1'b0; // RL12
					end
				endcase
			end else if (st_reg.bitcnt == TWT_ACK_SLOT) begin
				st_next.bitcnt = 4'h0; // RL4 RL16
				st_next.sda_oe = 1'b0; // RL13
				if ((st_reg.state == TWT_ST_ADDR && st_reg.shreg[0]) ||
				    st_reg.state == TWT_ST_TX) begin
					// Load the next byte and put its top bit out
					st_next.state  = TWT_ST_TX;
					st_next.shreg  = tx_data;
					st_next.sda_oe = !tx_data[7]; // RL3 RL4
					st_next.take_p = 1'b1;
				end else if (st_reg.state == TWT_ST_ADDR) begin
					st_next.state = TWT_ST_RX;
				end
			end else begin
				st_next.bitcnt = st_reg.bitcnt + 4'h1; // RL5
				if (st_reg.state == TWT_ST_TX) begin
					st_next.shreg  = {st_reg.shreg[6:0], 1'b0};
					st_next.sda_oe = !st_reg.shreg[6]; // RL3
				end
			end
		end
		st_next.standby = (st_next.state == TWT_ST_STANDBY) && !write_busy; // RL15
	end

	// One register stage for all state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg          <= '0;
			st_reg.scl_s1   <= 1'b1;
			st_reg.scl_s2   <= 1'b1;
			st_reg.scl_d    <= 1'b1;
			st_reg.sda_s1   <= 1'b1;
			st_reg.sda_s2   <= 1'b1;
			st_reg.sda_d    <= 1'b1;
			st_reg.state    <= TWT_ST_POR;
		end else begin
			st_reg <= st_next;
		end
	end

	twt_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_rx_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (st_reg.push),
		.in_ready  (fifo_ready),
		.in_data   (FIFO_WIDTH'(st_reg.shreg)),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_data)
	);

	// Outputs straight from the state word
	assign sda_o        = st_reg.sda_o;
	assign sda_oe       = st_reg.sda_oe;
	assign tx_take      = st_reg.take_p;
	assign standby      = st_reg.standby;
	assign bus_idle     = st_reg.bus_idle;
	assign start_seen   = st_reg.start_p;
	assign stop_seen    = st_reg.stop_p;
	assign write_launch = st_reg.launch_p;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_por_stays_quiet: assert property ( // RL1
		st_reg.state == TWT_ST_POR |-> !st_reg.sda_oe)
		else $error("line driven before power-on release");
	a_drive_after_fall: assert property ( // RL3
		$rose(st_reg.sda_oe) |-> $past(scl_fall))
		else $error("data drive began without a clock fall");
	a_bit_count_range: assert property ( // RL4
		st_reg.bitcnt <= TWT_ACK_SLOT)
		else $error("bit count beyond answer slot");
	a_start_restarts: assert property ( // RL7
		start_c && st_reg.state != TWT_ST_POR |=>
		st_reg.state == TWT_ST_ADDR && st_reg.bitcnt == 4'h0 && !st_reg.sda_oe)
		else $error("start did not restart the command");
	a_stop_to_standby: assert property ( // RL8
		stop_c && st_reg.state != TWT_ST_POR && !start_c |=>
		st_reg.state == TWT_ST_STANDBY ##1 (st_reg.standby || write_busy))
		else $error("stop did not return to standby");
	a_standby_silent: assert property ( // RL9
		st_reg.state == TWT_ST_STANDBY |-> !st_reg.sda_oe)
		else $error("line driven in standby");
	a_push_with_ack: assert property ( // RL12
		st_reg.push |-> st_reg.sda_oe && st_reg.bitcnt == TWT_ACK_SLOT)
		else $error("byte stored without acknowledge");
	a_ack_released: assert property ( // RL13
		scl_fall && !start_c && !stop_c && st_reg.bitcnt == TWT_ACK_SLOT &&
		(st_reg.state == TWT_ST_RX || (st_reg.state == TWT_ST_ADDR && !st_reg.shreg[0]))
		|=> !st_reg.sda_oe)
		else $error("answer not released after ninth clock");
	a_nack_releases: assert property ( // RL14
		st_reg.state == TWT_ST_TX && scl_rise && !start_c && !stop_c &&
		st_reg.bitcnt == TWT_ACK_SLOT && st_reg.sda_s2 |=>
		st_reg.state == TWT_ST_IGNORE && !st_reg.sda_oe)
		else $error("no-ack did not release the line");
	a_mismatch_nack: assert property ( // RL18
		st_reg.state == TWT_ST_ADDR && scl_fall && !start_c && !stop_c &&
		st_reg.bitcnt == TWT_LAST_DATA_BIT && !addr_hit |=> !st_reg.sda_oe)
		else $error("foreign address acknowledged");

	c_start_seen:  cover property (st_reg.start_p);
	c_read_byte:   cover property (st_reg.take_p);
	c_byte_stored: cover property (st_reg.push);
	c_write_stop:  cover property (st_reg.launch_p);
endmodule

/* rtl/twt_pkg.sv */
// Purpose: Shared types and constants for the two-wire target bit engine
// Assumes: Core clock well above the serial clock so every edge is seen
// Notes:   State codes follow a Gray walk in the order they are listed
package twt_pkg;

	// ==========================================================
	// Bus framing
	localparam int          TWT_BITS_PER_BYTE = 8;
	localparam logic [3:0]  TWT_ACK_SLOT      = 4'h8;
	localparam logic [3:0]  TWT_LAST_DATA_BIT = 4'h7;
	localparam logic [3:0]  TWT_TYPE_ID       = 4'hA;

	// ==========================================================
	// Power-up wait owed by the master after supply is stable
	localparam int          TWT_FIRST_COMMAND_WAIT_US = 100;
	localparam int          TWT_CLK_MHZ               = 100;
	localparam int          TWT_FIRST_COMMAND_WAIT_CYC =
		TWT_FIRST_COMMAND_WAIT_US * TWT_CLK_MHZ;

	// ==========================================================
	// Sizes of the receive buffer
	localparam int          TWT_FIFO_WIDTH = 8;
	localparam int          TWT_FIFO_DEPTH = 32;

	// ==========================================================
	// Engine states
	typedef enum logic [2:0] {
		TWT_ST_POR     = 3'b000,
		TWT_ST_STANDBY = 3'b001,
		TWT_ST_ADDR    = 3'b011,
		TWT_ST_RX      = 3'b010,
		TWT_ST_TX      = 3'b110,
		TWT_ST_IGNORE  = 3'b111
	} twt_state_t;

	// ==========================================================
	// Whole engine state, registered as one word
	typedef struct packed {
		logic       scl_s1;
		logic       scl_s2;
		logic       scl_d;
		logic       sda_s1;
		logic       sda_s2;
		logic       sda_d;
		logic       por_s1;
		logic       por_s2;
		logic [2:0] addr_s1;
		logic [2:0] addr_s2;
		twt_state_t state;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic       wr_pending;
		logic       sda_o;
		logic       sda_oe;
		logic       standby;
		logic       bus_idle;
		logic       start_p;
		logic       stop_p;
		logic       launch_p;
		logic       take_p;
		logic       push;
		logic       bit_armed;
	} twt_regs_t;

endpackage

/* sim/twt_master.sv */
// Purpose: Bus master model that drives the serial clock and pulls the data wire
// Assumes: The data wire is open drain with a pull-up in the bench
// Notes:   The clock stands still between frames
`timescale 1ns/1ps

// ==========================================================
// Master model
module twt_master
	import twt_pkg::*;
(
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	localparam realtime H = 62.5; // Half of a 125 ns link period

	// Idle bus at time zero
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Wait owed after power comes up, before the first command
	task automatic pup_wait();
		#(TWT_FIRST_COMMAND_WAIT_US * 1us);
	endtask

	// One clock; data moves mid-low so it is never seen moving while high
	task automatic bit_io(input logic b, output logic r);
		#(H / 2) sda_low = !b;
		#(H / 2) scl = 1'b1;
		#H r = sda;
		scl = 1'b0;
	endtask

	// Nine clocks back to back, most significant bit first
	task automatic byte_io(input logic [8:0] t, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			bit_io(t[i], q[i]);
		end
	endtask

	// Start, or repeated start when the clock is low
	task automatic start();
		if (!scl) begin
			#(H / 2) sda_low = 1'b0;
			#(H / 2) scl = 1'b1;
			#H;
		end
		sda_low = 1'b1;
		#H scl = 1'b0;
	endtask

	// Stop, leaving both lines high
	task automatic stop();
		#(H / 2) sda_low = 1'b1;
		#(H / 2) scl = 1'b1;
		#H sda_low = 1'b0;
		#H;
	endtask
endmodule

/* sim/two_wire_target_bit_engine_test.sv */
// Purpose: Self-checking bench for the two-wire target bit engine
// Assumes: Master model on the link, byte source and consumer on the core side
// Notes:   Expected bytes come from queues kept in the bench; expected answers are computed per byte
`timescale 1ns/1ps

// ==========================================================
// Bench top
module two_wire_target_bit_engine_test
	import twt_pkg::*;
();
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       por_release = 1'b0;
	logic       write_busy = 1'b0;
	logic       rx_ready = 1'b1;
	logic [2:0] dev_addr = 3'h5;
	logic [7:0] tx_data = 8'h3c;
	logic [7:0] rx_data;
	logic       scl, m_low, sda_oe, sda_o, tx_take, rx_valid, standby, bus_idle, write_launch;
	logic       start_seen, stop_seen;
	int         n_start = 0;
	int         n_stop = 0;
	logic       wl_seen = 1'b0;
	logic [8:0] r;
	integer     seed = 32'h96b3_c38e;
	int         error_cnt = 0;
	int         check_count = 0;
	int         cyc = 0;
	logic [7:0] rxq[$];
	logic [7:0] txq[$];
	wire        sda = !(m_low | sda_oe); // Pull-up wins when nobody pulls

	// 100 MHz core clock
	always #5 clk = !clk;

	twt_engine u_dut (.clk(clk), .rst_n(rst_n), .por_release(por_release),
		.dev_addr(dev_addr), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.write_busy(write_busy), .tx_data(tx_data), .tx_take(tx_take), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_data(rx_data), .standby(standby), .bus_idle(bus_idle),
		.start_seen(start_seen), .stop_seen(stop_seen), .write_launch(write_launch));
	twt_master u_m (.scl(scl), .sda_low(m_low), .sda(sda));

	// ==========================================================
	// Checking and reporting
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tend(input int n);
		$display("test %0d done", n);
	endtask

	task automatic stop_test();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Address byte; a hit needs type code, straps, power good and no write
	task automatic adr(input logic [7:0] a);
		logic hit;
		hit = a[7:1] == {TWT_TYPE_ID, dev_addr} && por_release && !write_busy;
		u_m.byte_io({a, 1'b1}, r);
		chk(8'(!r[0]), 8'(hit));
	endtask

	// Data byte into the buffer; expectation queued first as the pop may come early
	task automatic wr(input logic [7:0] d, input logic ack);
		if (ack) rxq.push_back(d);
		u_m.byte_io({d, 1'b1}, r);
		chk(8'(!r[0]), 8'(ack));
		#60 chk(8'(sda), 8'h01);
	endtask

	// Data byte from the device, answered by the master
	task automatic rd(input logic nack);
		u_m.byte_io({8'hff, nack}, r);
		chk(r[8:1], txq.pop_front());
	endtask

	// ==========================================================
	// Byte source, buffer consumer and hang guard
	always @(posedge clk) begin
		if (tx_take === 1'b1) begin
			txq.push_back(tx_data);
			tx_data <= 8'($random(seed));
		end
		if (rx_valid === 1'b1 && rx_ready) chk(rx_data, rxq.pop_front());
		if (write_launch === 1'b1) wl_seen = 1'b1;
		if (start_seen === 1'b1) n_start++;
		if (stop_seen === 1'b1) n_stop++;
		if (sda_oe === 1'b1) chk(8'(sda_o), 8'h00);
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			$display("ERROR %0t timeout", $time);
			stop_test();
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		dev_addr <= 3'($random(seed));
		// Traffic before power good must be ignored
		u_m.start();
		adr({TWT_TYPE_ID, dev_addr, 1'b0});
		u_m.stop();
		chk(8'(standby), 8'h00);
		@(posedge clk) por_release <= 1'b1;
		u_m.pup_wait();
		chk(8'(standby), 8'h01);
		chk(8'(bus_idle), 8'h01);
		tend(1);
		// Write of three data bytes, then stop
		u_m.start();
		adr({TWT_TYPE_ID, dev_addr, 1'b0});
		chk(8'(standby), 8'h00);
		repeat (3) wr(8'($random(seed)), 1'b1);
		u_m.stop();
		#100 chk(8'(wl_seen), 8'h01);
		chk(8'(standby), 8'h01);
		chk(8'(n_start), 8'h01);
		chk(8'(n_stop), 8'h01);
		tend(2);
		// Wrong straps, then a busy internal write: both refused
		for (int i = 0; i < 2; i++) begin
			@(posedge clk) write_busy <= i[0];
			u_m.start();
			adr({TWT_TYPE_ID, dev_addr ^ 3'(i ^ 1), 1'b0});
			u_m.stop();
		end
		@(posedge clk) write_busy <= 1'b0;
		tend(3);
		// Read: master acks twice, then refuses and the line must free up
		txq.delete();
		u_m.start();
		adr({TWT_TYPE_ID, dev_addr, 1'b1});
		rd(1'b0);
		rd(1'b0);
		rd(1'b1);
		#60 chk(8'(sda), 8'h01);
		u_m.stop();
		tend(4);
		// Repeated start halfway through a byte
		u_m.start();
		adr({TWT_TYPE_ID, dev_addr, 1'b0});
		repeat (4) u_m.bit_io(1'b0, r[0]);
		txq.delete();
		u_m.start();
		adr({TWT_TYPE_ID, dev_addr, 1'b1});
		rd(1'b1);
		u_m.stop();
		tend(5);
		// Stalled consumer: fill until refused, then drain
		@(posedge clk) rx_ready <= 1'b0;
		u_m.start();
		adr({TWT_TYPE_ID, dev_addr, 1'b0});
		repeat (TWT_FIFO_DEPTH + 1) wr(8'($random(seed)), 1'(rxq.size() < TWT_FIFO_DEPTH));
		u_m.stop();
		@(posedge clk) rx_ready <= 1'b1;
		repeat (50) @(posedge clk);
		chk(8'(rxq.size()), 8'h00);
		chk(8'(rx_valid), 8'h00);
		tend(6);
		// Read cut off after three bits, then nine dummy clocks; the line must be free on the last
		txq.delete();
		u_m.start();
		adr({TWT_TYPE_ID, dev_addr, 1'b1});
		repeat (3) u_m.bit_io(1'b1, r[0]);
		repeat (9) u_m.bit_io(1'b1, r[0]);
		chk(8'(r[0]), 8'h01);
		u_m.start();
		adr({TWT_TYPE_ID, dev_addr, 1'b0});
		u_m.stop();
		tend(7);
		stop_test();
	end
endmodule
